/* File: src/flash_defs.vh */
// Notes on behaviour
// - Invert bit swaps protected and free ranges.
// - Fine granularity protects 4 to 32 KB window.
// - Program or erase touching protection is ignored.
// - Page write is opcode, three address bytes, data.
// - Page write starts timed busy program cycle.
// - At most 256 bytes, one page, clears bits.
// - Erase leaves every byte all ones.
// - Sector, block and chip erase, own durations.
// - Chip select low means active power state.
// - Chip select high: standby after cycle ends.
// - Sleep entered only by sleep command.
// - Sleep left only by release command.
// - Asleep, every other command is ignored.
// - Busy flag visible during internal cycles.
// - Write latch clears when cycle completes.
// - Write commands need whole bytes before deselect.
`ifndef FLASH_DEFS_VH
`define FLASH_DEFS_VH

// ==========================================================
// Command codes
`define OP_WRITE_ENABLE   8'h01
`define OP_PAGE_WRITE     8'h02
`define OP_SMALL_ERASE    8'h03
`define OP_LARGE_ERASE    8'h04
`define OP_CHIP_ERASE     8'h05
`define OP_STATUS_WRITE   8'h06
`define OP_SLEEP_ENTER    8'h07
`define OP_SLEEP_RELEASE  8'h08

// ==========================================================
// Command lengths in bytes
`define LEN_SHORT         9'h001
`define LEN_STATUS        9'h002
`define LEN_ADDR          9'h004
`define LEN_PAGE_MIN      9'h005

// ==========================================================
// Array geometry
`define ARRAY_TOP         22'h3FFFFF
`define PAGE_MASK         22'h0000FF
`define SECTOR_MASK       22'h000FFF
`define BLOCK_MASK        22'h00FFFF
`define COARSE_UNIT       22'h010000
`define FINE_UNIT         22'h001000
`define FINE_MAX          22'h008000

// ==========================================================
// Erase kinds
`define ERASE_SECTOR      2'h0
`define ERASE_BLOCK       2'h1
`define ERASE_CHIP        2'h2

// ==========================================================
// Timing
`define CLK_MHZ           50
`define PROG_TIME_US      1000
`define STATUS_TIME_US    5000
`define SECTOR_TIME_US    50000
`define BLOCK_TIME_US     200000
`define CHIP_TIME_US      2000000

`endif

/* File: src/protect_range_decode.v */
`timescale 1ns/1ps
`include "flash_defs.vh"
module protect_range_decode (
  // Protection configuration
  input  wire        sector_granularity_bit_in,
  input  wire        top_bottom_select_in,
  input  wire [2:0]  protect_size_in,
  input  wire        protect_invert_in,
  // Protected range
  output reg         prot_any_out,
  output reg  [21:0] prot_lo_out,
  output reg  [21:0] prot_hi_out
);

  reg [21:0] size;

  // ==========================================================
  // Range decode
  always @* begin
    size = 22'h000000;
    if (sector_granularity_bit_in) begin
      if (protect_size_in[2]) begin
        size = `FINE_MAX;
      end else begin
        size = `FINE_UNIT << (protect_size_in[1:0] - 2'h1);
      end
    end else begin
      size = `COARSE_UNIT << (protect_size_in - 3'h1);
    end
    prot_any_out = 1'b1;
    prot_lo_out  = 22'h000000;
    prot_hi_out  = `ARRAY_TOP;
    if (protect_size_in == 3'h0) begin
      prot_any_out = protect_invert_in;
    end else if (protect_size_in == 3'h7) begin
      prot_any_out = ~protect_invert_in;
    end else if (!protect_invert_in) begin
      if (top_bottom_select_in) begin
        prot_hi_out = size - 22'h000001;
      end else begin
        prot_lo_out = `ARRAY_TOP - size + 22'h000001;
      end
    end else if (top_bottom_select_in) begin
      // Free window at the bottom, the rest stays locked
      prot_lo_out = size;
    end else begin
      prot_hi_out = `ARRAY_TOP - size;
    end
  end

endmodule

/* File: src/flash_protect_program_erase.v */
`timescale 1ns/1ps
`include "flash_defs.vh"
module flash_protect_program_erase #(
  parameter [31:0] PROG_CYCLES   = `PROG_TIME_US * `CLK_MHZ,
  parameter [31:0] STATUS_CYCLES = `STATUS_TIME_US * `CLK_MHZ,
  parameter [31:0] SECTOR_CYCLES = `SECTOR_TIME_US * `CLK_MHZ,
  parameter [31:0] BLOCK_CYCLES  = `BLOCK_TIME_US * `CLK_MHZ,
  parameter [31:0] CHIP_CYCLES   = `CHIP_TIME_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_in,
  // Serial link from the host
  input  wire        cs_n_in,
  input  wire        sclk_in,
  input  wire        mosi_in,
  // Protection configuration
  input  wire        sector_granularity_bit_in,
  input  wire        top_bottom_select_in,
  input  wire        protect_size_bit2_in,
  input  wire        protect_size_bit1_in,
  input  wire        protect_size_bit0_in,
  input  wire        protect_invert_in,
  // Status
  output wire        busy_out,
  output wire        write_latch_flag_out,
  output wire        active_out,
  output wire        standby_out,
  output wire        sleep_out,
  // Page latch writes toward the array
  output reg         data_byte_valid_out,
  output reg  [21:0] data_addr_out,
  output reg  [7:0]  data_byte_out,
  // Array operations
  output reg         program_start_out,
  output reg         erase_start_out,
  output reg  [1:0]  erase_kind_out,
  output reg  [21:0] op_addr_out,
  output reg         status_write_out,
  output reg  [7:0]  status_byte_out
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  reg  [2:0]  cs_sync_r;
  reg  [2:0]  sclk_sync_r;
  reg  [1:0]  mosi_sync_r;
  reg  [2:0]  bit_cnt_r;
  reg  [6:0]  shift_r;
  reg  [8:0]  byte_cnt_r;
  reg  [7:0]  opcode_r;
  reg  [23:0] addr_r;
  reg  [7:0]  page_idx_r;
  reg         wel_r;
  reg         sleep_r;
  reg  [1:0]  state_r;
  reg  [31:0] timer_r;

  wire        prot_any;
  wire [21:0] prot_lo;
  wire [21:0] prot_hi;
  wire        selected;
  wire        cs_fall;
  wire        cs_rise;
  wire        sclk_rise;
  wire        byte_done;
  wire [7:0]  byte_in;
  wire        busy;
  wire        whole;
  wire        may_write;
  wire [21:0] a;

  // ==========================================================
  // Overlap test of a region against the protected range
  function hits;
    input [21:0] lo;
    input [21:0] hi;
    input [21:0] plo;
    input [21:0] phi;
    input        pany;
    begin
      hits = pany && !((hi < plo) || (lo > phi));
    end
  endfunction

  protect_range_decode u_decode (
    .sector_granularity_bit_in (sector_granularity_bit_in),
    .top_bottom_select_in      (top_bottom_select_in),
    .protect_size_in           ({protect_size_bit2_in, protect_size_bit1_in,
                                 protect_size_bit0_in}),
    .protect_invert_in         (protect_invert_in),
    .prot_any_out              (prot_any),
    .prot_lo_out               (prot_lo),
    .prot_hi_out               (prot_hi)
  );

  // ==========================================================
  // Link sampling; the link clock is only data to us
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cs_sync_r   <= 3'h7;
      sclk_sync_r <= 3'h0;
      mosi_sync_r <= 2'h0;
    end else begin
      cs_sync_r   <= {cs_sync_r[1:0], cs_n_in};
      sclk_sync_r <= {sclk_sync_r[1:0], sclk_in};
      mosi_sync_r <= {mosi_sync_r[0], mosi_in};
    end
  end

  assign selected  = ~cs_sync_r[1];
  assign cs_fall   = ~cs_sync_r[1] & cs_sync_r[2];
  assign cs_rise   = cs_sync_r[1] & ~cs_sync_r[2];
  assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
  assign byte_done = selected && sclk_rise && (bit_cnt_r == 3'h7);
  assign byte_in   = {shift_r, mosi_sync_r[1]};
  assign busy      = state_r[1];
  assign whole     = (bit_cnt_r == 3'h0);
  // Array writes only with the latch set, awake and idle
  assign may_write = wel_r && !sleep_r && !busy;
  assign a         = addr_r[21:0];

  // ==========================================================
  // Power and status view
  assign busy_out             = busy;
  assign write_latch_flag_out = wel_r;
  assign active_out           = selected | busy;
  assign standby_out          = ~selected & ~busy & ~sleep_r;
  assign sleep_out            = sleep_r;

  // ==========================================================
  // Command engine
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bit_cnt_r           <= 3'h0;
      shift_r             <= 7'h00;
      byte_cnt_r          <= 9'h000;
      opcode_r            <= 8'h00;
      addr_r              <= 24'h000000;
      page_idx_r          <= 8'h00;
      wel_r               <= 1'b0;
      sleep_r             <= 1'b0;
      state_r             <= ST_IDLE;
      timer_r             <= 32'h00000000;
      data_byte_valid_out <= 1'b0;
      data_addr_out       <= 22'h000000;
      data_byte_out       <= 8'h00;
      program_start_out   <= 1'b0;
      erase_start_out     <= 1'b0;
      erase_kind_out      <= `ERASE_SECTOR;
      op_addr_out         <= 22'h000000;
      status_write_out    <= 1'b0;
      status_byte_out     <= 8'h00;
    end else begin
      data_byte_valid_out <= 1'b0;
      program_start_out   <= 1'b0;
      erase_start_out     <= 1'b0;
      status_write_out    <= 1'b0;

      if (cs_fall) begin
        bit_cnt_r  <= 3'h0;
        byte_cnt_r <= 9'h000;
        page_idx_r <= 8'h00;
      end else if (selected && sclk_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        shift_r   <= byte_in[6:0];
        if (byte_done) begin
          if (byte_cnt_r != 9'h1FF) begin
            byte_cnt_r <= byte_cnt_r + 9'h001;
          end
          if (byte_cnt_r == 9'h000) begin
            opcode_r <= byte_in;
          end else if (byte_cnt_r < `LEN_ADDR) begin
            addr_r <= {addr_r[15:0], byte_in};
          end else if (opcode_r == `OP_PAGE_WRITE && may_write &&
                       !hits(a & ~`PAGE_MASK, a | `PAGE_MASK,
                             prot_lo, prot_hi, prot_any)) begin
            // Offset wraps inside the page, never into the next
            data_byte_valid_out <= 1'b1;
            data_addr_out       <= {a[21:8], a[7:0] + page_idx_r};
            data_byte_out       <= byte_in;
            page_idx_r          <= page_idx_r + 8'h01;
          end
        end
      end

      if (cs_rise && whole) begin
        if (sleep_r) begin
          if (opcode_r == `OP_SLEEP_RELEASE) begin
            sleep_r <= 1'b0;
          end
        end else if (!busy) begin
          case (opcode_r)
            `OP_WRITE_ENABLE: begin
              if (byte_cnt_r == `LEN_SHORT) begin
                wel_r <= 1'b1;
              end
            end
            `OP_SLEEP_ENTER: begin
              if (byte_cnt_r == `LEN_SHORT) begin
                sleep_r <= 1'b1;
              end
            end
            `OP_STATUS_WRITE: begin
              if (wel_r && byte_cnt_r == `LEN_STATUS) begin
                status_write_out <= 1'b1;
                status_byte_out  <= addr_r[7:0];
                state_r          <= ST_BUSY;
                timer_r          <= STATUS_CYCLES - 32'h1;
              end
            end
            `OP_PAGE_WRITE: begin
              if (wel_r && byte_cnt_r >= `LEN_PAGE_MIN &&
                  !hits(a & ~`PAGE_MASK, a | `PAGE_MASK, prot_lo, prot_hi, prot_any)) begin
                program_start_out <= 1'b1;
                op_addr_out       <= a & ~`PAGE_MASK;
                state_r           <= ST_BUSY;
                timer_r           <= PROG_CYCLES - 32'h1;
              end
            end
            `OP_SMALL_ERASE: begin
              if (wel_r && byte_cnt_r == `LEN_ADDR &&
                  !hits(a & ~`SECTOR_MASK, a | `SECTOR_MASK,
                        prot_lo, prot_hi, prot_any)) begin
                erase_start_out <= 1'b1;
                erase_kind_out  <= `ERASE_SECTOR;
                op_addr_out     <= a & ~`SECTOR_MASK;
                state_r         <= ST_BUSY;
                timer_r         <= SECTOR_CYCLES - 32'h1;
              end
            end
            `OP_LARGE_ERASE: begin
              if (wel_r && byte_cnt_r == `LEN_ADDR &&
                  !hits(a & ~`BLOCK_MASK, a | `BLOCK_MASK, prot_lo, prot_hi, prot_any)) begin
                erase_start_out <= 1'b1;
                erase_kind_out  <= `ERASE_BLOCK;
                op_addr_out     <= a & ~`BLOCK_MASK;
                state_r         <= ST_BUSY;
                timer_r         <= BLOCK_CYCLES - 32'h1;
              end
            end
            `OP_CHIP_ERASE: begin
              if (wel_r && byte_cnt_r == `LEN_SHORT &&
                  !hits(22'h000000, `ARRAY_TOP, prot_lo, prot_hi, prot_any)) begin
                erase_start_out <= 1'b1;
                erase_kind_out  <= `ERASE_CHIP;
                op_addr_out     <= 22'h000000;
                state_r         <= ST_BUSY;
                timer_r         <= CHIP_CYCLES - 32'h1;
              end
            end
            default: begin
            end
          endcase
        end
      end

      // ==========================================================
      // Internal cycle timer
      case (state_r)
        ST_IDLE: begin
        end
        ST_BUSY: begin
          if (timer_r == 32'h00000000) begin
            state_r <= ST_IDLE;
            wel_r   <= 1'b0;
          end else begin
            timer_r <= timer_r - 32'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: testbench/flash_protect_program_erase_sva.sv */
`timescale 1ns/1ps
module flash_protect_program_erase_chk #(
  parameter [31:0] PROG_CYCLES   = 32'h00000014,
  parameter [31:0] STATUS_CYCLES = 32'h00000014,
  parameter [31:0] SECTOR_CYCLES = 32'h00000014,
  parameter [31:0] BLOCK_CYCLES  = 32'h00000014,
  parameter [31:0] CHIP_CYCLES   = 32'h00000014
) (
  // Clock, reset and link
  input wire        clock_in,
  input wire        rst_in,
  input wire        cs_n_in,
  // Observed outputs
  input wire        busy_out,
  input wire        write_latch_flag_out,
  input wire        active_out,
  input wire        standby_out,
  input wire        sleep_out,
  input wire        data_byte_valid_out,
  input wire        program_start_out,
  input wire        erase_start_out,
  input wire [1:0]  erase_kind_out,
  input wire [21:0] op_addr_out,
  input wire        status_write_out
);
  // ==========================================================
  // Busy length bookkeeping
  logic [31:0] cnt_r;
  logic [31:0] exp_r;
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 32'h0;
      exp_r <= 32'h0;
    end else if (program_start_out || erase_start_out || status_write_out) begin
      cnt_r <= 32'h1;
      // Busy is sampled high on exactly the cycle count of edges, the commit edge included
      exp_r <= program_start_out ? PROG_CYCLES : status_write_out ? STATUS_CYCLES :
               erase_kind_out == 2'h0 ? SECTOR_CYCLES :
               erase_kind_out == 2'h1 ? BLOCK_CYCLES : CHIP_CYCLES;
    end else if (busy_out) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_commit;
    program_start_out || erase_start_out || status_write_out;
  endsequence
  sequence s_selected;
    !cs_n_in [*3];
  endsequence
  AST_PROG_BUSY: assert property (program_start_out |-> busy_out && write_latch_flag_out)
    else $error("page commit without busy or latch");
  AST_PAGE_ALIGN: assert property (program_start_out |-> op_addr_out[7:0] == 8'h00)
    else $error("page commit base not page aligned");
  AST_ERASE_ALIGN: assert property (erase_start_out |-> busy_out && (erase_kind_out == 2'h0 ?
    op_addr_out[11:0] == 12'h000 : erase_kind_out == 2'h1 ? op_addr_out[15:0] == 16'h0000 :
    erase_kind_out == 2'h2 && op_addr_out == 22'h000000))
    else $error("erase region base or kind wrong");
  AST_BUSY_CAUSE: assert property ($rose(busy_out) |-> s_commit)
    else $error("busy rose without a commit");
  AST_BUSY_LEN: assert property ($fell(busy_out) |-> cnt_r == exp_r)
    else $error("busy length differs from cycle time");
  AST_WEL_CLEAR: assert property ($fell(busy_out) |-> !write_latch_flag_out)
    else $error("latch still set after cycle end");
  AST_ACTIVE: assert property (s_selected |-> active_out)
    else $error("selected but not active");
  AST_BUSY_ACTIVE: assert property (busy_out |-> active_out && !standby_out)
    else $error("standby while a cycle runs");
  AST_SLEEP_QUIET: assert property (sleep_out |-> !(program_start_out || erase_start_out ||
    status_write_out || data_byte_valid_out))
    else $error("array activity while asleep");
  AST_SLEEP_ENTRY: assert property ($rose(sleep_out) |-> cs_n_in && !busy_out)
    else $error("sleep entered outside command execution");
  AST_SLEEP_EXIT: assert property ($fell(sleep_out) |-> cs_n_in)
    else $error("sleep left outside command execution");
endmodule

bind flash_protect_program_erase flash_protect_program_erase_chk #(
  .PROG_CYCLES(PROG_CYCLES), .STATUS_CYCLES(STATUS_CYCLES), .SECTOR_CYCLES(SECTOR_CYCLES),
  .BLOCK_CYCLES(BLOCK_CYCLES), .CHIP_CYCLES(CHIP_CYCLES)
) u_chk (
  .clock_in(clock_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .busy_out(busy_out),
  .write_latch_flag_out(write_latch_flag_out), .active_out(active_out),
  .standby_out(standby_out), .sleep_out(sleep_out), .data_byte_valid_out(data_byte_valid_out),
  .program_start_out(program_start_out), .erase_start_out(erase_start_out),
  .erase_kind_out(erase_kind_out), .op_addr_out(op_addr_out),
  .status_write_out(status_write_out)
);

/* File: testbench/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  // Clock reference
  input  wire logic clock_in,
  // Serial link
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      mosi_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  // ==========================================================
  // Mode 0 frame; a nonzero cut drops bits to break the byte boundary
  task frame(input logic [7:0] q[$], input int cut);
    int i;
    @(posedge clock_in);
    #7 cs_n_out = 1'b0;
    #160;
    for (i = 0; i < q.size() * 8 - cut; i++) begin
      mosi_out = q[i / 8][7 - i % 8];
      #80 sclk_out = 1'b1;
      #80 sclk_out = 1'b0;
    end
    #80 cs_n_out = 1'b1;
    // Released line shows the inverse so a stale value is never trusted
    mosi_out = ~mosi_out;
    #400;
  endtask
endmodule

/* File: testbench/flash_protect_program_erase_bench.sv */
`timescale 1ns/1ps
`include "flash_defs.vh"
module flash_protect_program_erase_bench;
  // ==========================================================
  // Signals
  logic        clock_in, rst_in;
  logic [5:0]  cfg;
  wire         cs_n, sclk, mosi, busy, write_latch_flag, act, stby, slp, dv, ps, es, sw;
  wire  [21:0] daddr, oaddr;
  wire  [7:0]  dbyte, sbyte;
  wire  [1:0]  kind;
  int          n_mismatch, n_compared, n_data;
  logic [2:0]  seen;
  logic [29:0] first;
  // Config {gran, tb, size[2:0], invert}, sector address, accepted
  logic [28:0] rows [17] = '{{6'h00, 22'h000000, 1'h1}, {6'h0E, 22'h000000, 1'h0},
    {6'h01, 22'h3FF000, 1'h0}, {6'h0F, 22'h3FF000, 1'h1}, {6'h03, 22'h3F0000, 1'h1},
    {6'h03, 22'h3EF000, 1'h0}, {6'h23, 22'h3FF000, 1'h1}, {6'h23, 22'h3FE000, 1'h0},
    {6'h33, 22'h000000, 1'h1}, {6'h33, 22'h001000, 1'h0}, {6'h39, 22'h007000, 1'h1},
    {6'h3B, 22'h008000, 1'h0}, {6'h3D, 22'h007000, 1'h1}, {6'h32, 22'h001000, 1'h1},
    {6'h12, 22'h00F000, 1'h0}, {6'h28, 22'h3F8000, 1'h0}, {6'h02, 22'h3E0000, 1'h1}};
  flash_protect_program_erase #(.PROG_CYCLES(60), .STATUS_CYCLES(30), .SECTOR_CYCLES(40),
    .BLOCK_CYCLES(50), .CHIP_CYCLES(60)) uut (
    .clock_in(clock_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk), .mosi_in(mosi),
    .sector_granularity_bit_in(cfg[5]), .top_bottom_select_in(cfg[4]),
    .protect_size_bit2_in(cfg[3]), .protect_size_bit1_in(cfg[2]),
    .protect_size_bit0_in(cfg[1]), .protect_invert_in(cfg[0]), .busy_out(busy),
    .write_latch_flag_out(write_latch_flag), .active_out(act), .standby_out(stby), .sleep_out(slp),
    .data_byte_valid_out(dv), .data_addr_out(daddr), .data_byte_out(dbyte),
    .program_start_out(ps), .erase_start_out(es), .erase_kind_out(kind),
    .op_addr_out(oaddr), .status_write_out(sw), .status_byte_out(sbyte));
  spi_host_model host (.clock_in(clock_in), .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi));
  // ==========================================================
  // Commit monitor
  always @(posedge clock_in) begin
    seen <= seen | {sw, es, ps};
    if (dv) begin
      if (n_data == 0) first <= {daddr, dbyte};
      n_data <= n_data + 1;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task clr;
    @(negedge clock_in);
    seen = 3'h0;
    n_data = 0;
  endtask
  task write_enable_cmd;
    host.frame('{`OP_WRITE_ENABLE}, 0);
  endtask
  task ers(input logic [7:0] op, input logic [21:0] a);
    host.frame('{op, {2'h0, a[21:16]}, a[15:8], a[7:0]}, 0);
  endtask
  // Bounded wait for the internal cycle to end
  task idle;
    int i;
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clock_in);
    chk(busy, 1'h0);
  endtask
  task test_done;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog, tests
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    #1000000;
    n_mismatch++;
    test_done;
  end
  initial begin
    rst_in = 1'b1;
    cfg = 6'h00;
    seen = 3'h0;
    n_data = 0;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk({busy, write_latch_flag, slp, stby}, 4'h1);
    foreach (rows[i]) begin
      @(posedge clock_in);
      cfg <= rows[i][28:23];
      write_enable_cmd;
      clr;
      ers(`OP_SMALL_ERASE, rows[i][22:1]);
      chk(seen, {1'b0, rows[i][0], 1'b0});
      if (rows[i][0]) begin
        chk({kind, oaddr}, {2'h0, rows[i][22:1]});
        idle;
        chk(write_latch_flag, 1'h0);
      end
    end
    @(posedge clock_in);
    cfg <= 6'h00;
    // Page write without and then with the write enable
    clr;
    host.frame('{`OP_PAGE_WRITE, 8'h00, 8'h01, 8'h23, 8'h5A, 8'h3C}, 0);
    chk({seen, n_data[7:0]}, 11'h000);
    write_enable_cmd;
    clr;
    host.frame('{`OP_PAGE_WRITE, 8'h00, 8'h01, 8'h23, 8'h5A, 8'h3C}, 0);
    chk({seen, n_data[7:0]}, {3'h1, 8'h02});
    chk(oaddr, 22'h000100);
    chk(first, {22'h000123, 8'h5A});
    chk({busy, stby, act}, 3'h5);
    idle;
    chk({busy, stby, write_latch_flag}, 3'h2);
    write_enable_cmd;
    clr;
    ers(`OP_LARGE_ERASE, 22'h123456);
    chk({seen, kind, oaddr}, {3'h2, 2'h1, 22'h120000});
    idle;
    write_enable_cmd;
    clr;
    host.frame('{`OP_CHIP_ERASE}, 0);
    chk({seen, kind, oaddr}, {3'h2, 2'h2, 22'h000000});
    idle;
    clr;
    ers(`OP_SMALL_ERASE, 22'h000000);
    chk(seen, 3'h0);
    write_enable_cmd;
    clr;
    host.frame('{`OP_SMALL_ERASE, 8'h00, 8'h00, 8'h00}, 1);
    chk(seen, 3'h0);
    clr;
    host.frame('{`OP_STATUS_WRITE, 8'hA5}, 0);
    chk({seen, sbyte, busy}, {3'h4, 8'hA5, 1'b1});
    idle;
    // Sleep blocks everything but its release
    host.frame('{`OP_SLEEP_ENTER}, 0);
    chk(slp, 1'h1);
    write_enable_cmd;
    clr;
    ers(`OP_SMALL_ERASE, 22'h000000);
    chk(seen, 3'h0);
    host.frame('{`OP_SLEEP_RELEASE}, 0);
    chk(slp, 1'h0);
    clr;
    ers(`OP_SMALL_ERASE, 22'h000000);
    chk(seen, 3'h0);
    // Reset in the middle of a chip erase
    write_enable_cmd;
    host.frame('{`OP_CHIP_ERASE}, 0);
    chk(busy, 1'h1);
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    chk({busy, write_latch_flag, stby}, 3'h1);
    rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk({busy, write_latch_flag, slp, stby, act}, 5'h02);
    // Recovery after the cut erase: a fresh erase must still be taken
    write_enable_cmd;
    clr;
    ers(`OP_SMALL_ERASE, 22'h000000);
    chk({seen, act}, 4'h5);
    idle;
    test_done;
  end
endmodule
